//--- hdl/ulpirm_consts.vh
// register map constants for the ulpi transceiver register bank
// assumes inclusion by the bank top-level design file only, by bare name
`ifndef ULPIRM_CONSTS_VH
`define ULPIRM_CONSTS_VH

// ----------------------------------------------------------------
// immediate addresses
// ----------------------------------------------------------------
`define ULPIRM_ADR_VEND_LO   6'h00
`define ULPIRM_ADR_VEND_HI   6'h01
`define ULPIRM_ADR_PART_LO   6'h02
`define ULPIRM_ADR_PART_HI   6'h03
`define ULPIRM_ADR_FUNC      6'h04
`define ULPIRM_ADR_IFC       6'h07
`define ULPIRM_ADR_DUAL      6'h0A
`define ULPIRM_ADR_IRQ_RISE  6'h0D
`define ULPIRM_ADR_IRQ_FALL  6'h10
`define ULPIRM_ADR_IRQ_STAT  6'h13
`define ULPIRM_ADR_IRQ_LATCH 6'h14
`define ULPIRM_ADR_DEBUG     6'h15
`define ULPIRM_ADR_SCRATCH   6'h16
`define ULPIRM_ADR_RSV_LO    6'h19
`define ULPIRM_ADR_RSV_HI    6'h2E
`define ULPIRM_ADR_EXT       6'h2F
`define ULPIRM_ADR_VENDSPEC  6'h30
`define ULPIRM_ADR_POWER     6'h3D

// ----------------------------------------------------------------
// extended space
// ----------------------------------------------------------------
`define ULPIRM_EXT_ALIAS_TOP 8'h3F

// ----------------------------------------------------------------
// access kind offsets within a triple
// ----------------------------------------------------------------
`define ULPIRM_OFS_WRITE     2'h0
`define ULPIRM_OFS_SET       2'h1
`define ULPIRM_OFS_CLEAR     2'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ULPIRM_RST_FUNC      8'h41
`define ULPIRM_RST_ZERO      8'h00

`endif

//--- hdl/ulpirm_wsc_reg.v
// one eight bit register with write, set and clear aliases
// assumes the caller decodes the three strobes, at most one per cycle
module ulpirm_wsc_reg #(
  parameter [7:0] RST_VAL = 8'h00
) (
  // clock and reset
  input  wire       core_clk,
  input  wire       rstn,
  // access strobes and byte
  input  wire       wr_stb,
  input  wire       set_stb,
  input  wire       clr_stb,
  input  wire [7:0] wdata,
  // contents
  output reg  [7:0] q_ff
);

  reg [7:0] nxt_q;

  always @* begin
    nxt_q = q_ff;
    if (wr_stb) begin
      nxt_q = wdata;
    end else if (set_stb) begin
      nxt_q = q_ff | wdata;
    end else if (clr_stb) begin
      nxt_q = q_ff & ~wdata;
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      q_ff <= RST_VAL;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule // ulpirm_wsc_reg

//--- hdl/ulpirm_decode.v
// decodes a register address into a triple index and access kind
// assumes addresses already folded onto the 6-bit immediate space
module ulpirm_decode (
  // address in
  input  wire [5:0] adr,
  // decoded result
  output reg  [4:0] triple,
  output reg  [1:0] kind
);

  // quotient and remainder by three without a divider; triples start at
  // 04h, so triple 0 stands for the single-byte locations below it
  integer   i;
  reg [6:0] base;
  reg [6:0] ofs;

  always @* begin
    triple = 5'h00;
    kind   = 2'h0;
    base   = 7'h04;
    ofs    = 7'h00;
    for (i = 0; i < 20; i = i + 1) begin
      if (({1'b0, adr} >= base) && ({1'b0, adr} < base + 7'h03)) begin
        triple = i[4:0] + 5'h01;
        ofs    = {1'b0, adr} - base;
        kind   = ofs[1:0];
      end
      base = base + 7'h03;
    end
  end

endmodule // ulpirm_decode

//--- hdl/ulpirm_bank.v
// ulpi transceiver register bank: immediate and extended register access
// assumes the bus framing logic presents one decoded access per cycle,
// in the single core_clk domain
//
// Contract
// - every immediate register is eight bits, extended 00h-3Fh alias the immediate space
// - read-only registers return contents and have no write, set or clear alias
// - a write address replaces the register with the data byte
// - a set address ORs the data byte into the register
// - a clear address zeroes register bits where the data byte has ones
// - vendor code is constant, low byte at 00h, high byte at 01h
// - part code is constant, low byte at 02h, high byte at 03h
// - rising enable reads 0Dh-0Fh, write 0Dh, set 0Eh, clear 0Fh
// - falling enable reads 10h-12h, write 10h, set 11h, clear 12h
// - interrupt status is read-only at 13h
// - interrupt latch is read-only at 14h
// - an immediate write to 2Fh requests extended access, not a register write
// - extended addresses 00h-3Fh alias the immediate registers
`include "ulpirm_consts.vh"

module ulpirm_bank #(
  parameter [7:0] VEND_CODE_LO = 8'h5A, // arbitrary value
  parameter [7:0] VEND_CODE_HI = 8'hA5, // arbitrary value
  parameter [7:0] PART_CODE_LO = 8'h3C, // arbitrary value
  parameter [7:0] PART_CODE_HI = 8'hC3  // arbitrary value
) (
  // clock and reset
  input  wire       core_clk,
  input  wire       rstn,
  // register access from the bus framer
  input  wire       acc_valid,
  input  wire       acc_write,
  input  wire       acc_ext,
  input  wire [7:0] acc_adr,
  input  wire [7:0] acc_wdata,
  output reg  [7:0] acc_rdata_ff,
  output reg        acc_rvalid_ff,
  output reg        ext_req_ff,
  // state from the transceiver core
  input  wire [7:0] irq_state,
  input  wire [7:0] irq_events,
  input  wire [7:0] line_debug,
  // control bytes to the transceiver core
  output wire [7:0] func_ctrl,
  output wire [7:0] ifc_ctrl,
  output wire [7:0] dual_ctrl,
  output wire [7:0] irq_en_rise,
  output wire [7:0] irq_en_fall,
  output wire [7:0] scratch,
  output wire [7:0] pwr_ctrl,
  // latch read acknowledge, lets the core clear captured events
  output reg        latch_read_ff
);

  // ----------------------------------------------------------------
  // address folding
  // ----------------------------------------------------------------
  // extended addresses above 3Fh are reserved; they are flagged so no
  // aliasing into the immediate map can happen by truncation
  wire       ext_rsv;
  wire [5:0] adr6;
  wire [4:0] triple;
  wire [1:0] kind;

  assign ext_rsv = acc_ext && (acc_adr > `ULPIRM_EXT_ALIAS_TOP);
  assign adr6    = acc_adr[5:0];

  ulpirm_decode u_dec (
    .adr    (adr6),
    .triple (triple),
    .kind   (kind)
  );

  // ----------------------------------------------------------------
  // write side
  // ----------------------------------------------------------------
  // triples of write, set, clear; power control is the 3Dh triple
  localparam [4:0] T_FUNC  = 5'd1;
  localparam [4:0] T_IFC   = 5'd2;
  localparam [4:0] T_DUAL  = 5'd3;
  localparam [4:0] T_RISE  = 5'd4;
  localparam [4:0] T_FALL  = 5'd5;
  localparam [4:0] T_SCR   = 5'd7;
  localparam [4:0] T_PWR   = 5'd20;
  localparam       NREG    = 7;

  wire       wr_ok;
  wire [4:0] reg_triple [0:NREG-1];
  wire [7:0] reg_rst    [0:NREG-1];
  wire [7:0] reg_q      [0:NREG-1];

  // immediate writes above 3Fh cannot occur; reserved extended ones are dropped
  assign wr_ok = acc_valid && acc_write && !ext_rsv;

  assign reg_triple[0] = T_FUNC;
  assign reg_triple[1] = T_IFC;
  assign reg_triple[2] = T_DUAL;
  assign reg_triple[3] = T_RISE;
  assign reg_triple[4] = T_FALL;
  assign reg_triple[5] = T_SCR;
  assign reg_triple[6] = T_PWR;

  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_reg
      wire hit;
      assign hit = wr_ok && (triple == reg_triple[g]);
      ulpirm_wsc_reg #(
        .RST_VAL ((g == 0) ? `ULPIRM_RST_FUNC : `ULPIRM_RST_ZERO)
      ) u_reg (
        .core_clk (core_clk),
        .rstn     (rstn),
        .wr_stb   (hit && (kind == `ULPIRM_OFS_WRITE)),
        .set_stb  (hit && (kind == `ULPIRM_OFS_SET)),
        .clr_stb  (hit && (kind == `ULPIRM_OFS_CLEAR)),
        .wdata    (acc_wdata),
        .q_ff     (reg_q[g])
      );
    end
  endgenerate

  assign func_ctrl   = reg_q[0];
  assign ifc_ctrl    = reg_q[1];
  assign dual_ctrl   = reg_q[2];
  assign irq_en_rise = reg_q[3];
  assign irq_en_fall = reg_q[4];
  assign scratch     = reg_q[5];
  assign pwr_ctrl    = reg_q[6];

  // ----------------------------------------------------------------
  // extended access request
  // ----------------------------------------------------------------
  // only an immediate write to 2Fh asks for the extended set; in the
  // extended map 2Fh is an alias and stores nothing either
  always @(posedge core_clk) begin
    if (!rstn) begin
      ext_req_ff <= 1'b0;
    end else begin
      ext_req_ff <= acc_valid && acc_write && !acc_ext && (adr6 == `ULPIRM_ADR_EXT);
    end
  end

  // ----------------------------------------------------------------
  // read side
  // ----------------------------------------------------------------
  reg [7:0] nxt_rdata;

  always @* begin
    nxt_rdata = 8'h00;
    if (!ext_rsv) begin
      case (triple)
        T_FUNC, T_IFC, T_DUAL, T_RISE, T_FALL, T_SCR, T_PWR: begin
          nxt_rdata = 8'h00;
        end
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
      // single-byte read-only locations first, then the triples
      case (adr6)
        `ULPIRM_ADR_VEND_LO:   nxt_rdata = VEND_CODE_LO;
        `ULPIRM_ADR_VEND_HI:   nxt_rdata = VEND_CODE_HI;
        `ULPIRM_ADR_PART_LO:   nxt_rdata = PART_CODE_LO;
        `ULPIRM_ADR_PART_HI:   nxt_rdata = PART_CODE_HI;
        `ULPIRM_ADR_IRQ_STAT:  nxt_rdata = irq_state;
        `ULPIRM_ADR_IRQ_LATCH: nxt_rdata = irq_events;
        `ULPIRM_ADR_DEBUG:     nxt_rdata = line_debug;
        default: begin
          case (triple)
            T_FUNC:  nxt_rdata = reg_q[0];
            T_IFC:   nxt_rdata = reg_q[1];
            T_DUAL:  nxt_rdata = reg_q[2];
            T_RISE:  nxt_rdata = reg_q[3];
            T_FALL:  nxt_rdata = reg_q[4];
            T_SCR:   nxt_rdata = (adr6 <= `ULPIRM_ADR_SCRATCH + 6'h02) ? reg_q[5] : 8'h00;
            T_PWR:   nxt_rdata = reg_q[6];
            default: nxt_rdata = 8'h00; // reserved and vendor range read zero
          endcase
        end
      endcase
    end
  end

  // registered answer; latch read pulse lets the core clear-on-read
  always @(posedge core_clk) begin
    if (!rstn) begin
      acc_rdata_ff  <= 8'h00;
      acc_rvalid_ff <= 1'b0;
      latch_read_ff <= 1'b0;
    end else begin
      acc_rvalid_ff <= acc_valid && !acc_write;
      latch_read_ff <= acc_valid && !acc_write && !ext_rsv && (adr6 == `ULPIRM_ADR_IRQ_LATCH);
      if (acc_valid && !acc_write) begin
        acc_rdata_ff <= nxt_rdata;
      end
    end
  end

endmodule // ulpirm_bank

//--- test/ulpirm_bank_props.sv
// checker for the ulpi register bank, watching its ports only
// assumes one clock domain and binds onto every ulpirm_bank instance
module ulpirm_bank_props #(
  parameter [7:0] VEND_CODE_LO = 8'h5A // arbitrary value
) (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rstn,
  // access side
  input wire logic       acc_valid,
  input wire logic       acc_write,
  input wire logic       acc_ext,
  input wire logic [7:0] acc_adr,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata_ff,
  input wire logic       acc_rvalid_ff,
  input wire logic       ext_req_ff,
  input wire logic       latch_read_ff,
  // core side
  input wire logic [7:0] irq_state,
  input wire logic [7:0] irq_events,
  input wire logic [7:0] func_ctrl,
  input wire logic [7:0] irq_en_rise,
  input wire logic [7:0] irq_en_fall,
  input wire logic [7:0] scratch
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire logic       rd  = acc_valid & ~acc_write;
  wire logic       ird = rd & ~acc_ext;
  wire logic       wr  = acc_valid & acc_write & ~acc_ext;
  wire logic [5:0] adr = acc_adr[5:0];
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  read_strobe_a: assert property (rd |=> acc_rvalid_ff) else $error("no read strobe");
  vend_low_a: assert property (ird && adr == 6'h00 |=> acc_rdata_ff == VEND_CODE_LO) else $error("vend lo");
  stat_read_a: assert property (ird && adr == 6'h13 |=> acc_rdata_ff == $past(irq_state)) else $error("stat");
  latch_read_a: assert property (ird && adr == 6'h14 |=> latch_read_ff && acc_rdata_ff == $past(irq_events))
    else $error("latch");
  ext_request_a: assert property (wr && adr == 6'h2F |=> ext_req_ff) else $error("ext req");
  ext_quiet_a: assert property (!(wr && adr == 6'h2F) |=> !ext_req_ff) else $error("ext req spurious");
  rise_write_a: assert property (wr && adr == 6'h0D |=> irq_en_rise == $past(acc_wdata)) else $error("wr");
  fall_set_a: assert property (wr && adr == 6'h11 |=> irq_en_fall == ($past(irq_en_fall) | $past(acc_wdata)))
    else $error("set");
  scratch_clear_a: assert property (wr && adr == 6'h18 |=> scratch == ($past(scratch) & ~$past(acc_wdata)))
    else $error("clr");
  ro_write_a: assert property (wr && adr == 6'h13 |=> $stable(func_ctrl) && $stable(scratch))
    else $error("ro write");
  ext_alias_a: assert property (rd && acc_ext && acc_adr == 8'h0F |=> acc_rdata_ff == $past(irq_en_rise))
    else $error("alias");
  cover property (wr && adr == 6'h2F);
  cover property (rd && acc_ext);
  cover property (ird && adr == 6'h14);
endmodule // ulpirm_bank_props

bind ulpirm_bank ulpirm_bank_props #(.VEND_CODE_LO(VEND_CODE_LO)) u_ulpirm_bank_props (.core_clk, .rstn,
  .acc_valid, .acc_write, .acc_ext, .acc_adr, .acc_wdata, .acc_rdata_ff, .acc_rvalid_ff, .ext_req_ff,
  .latch_read_ff, .irq_state, .irq_events, .func_ctrl, .irq_en_rise, .irq_en_fall, .scratch);

//--- test/ulpirm_link_model.sv
// link controller model issuing single byte accesses to the bank
// assumes the bank takes an access at the edge where acc_valid is high
module ulpirm_link_model (
  // clock
  input  wire logic       core_clk,
  // access out
  output logic            acc_valid,
  output logic            acc_write,
  output logic            acc_ext,
  output logic [7:0]      acc_adr,
  output logic [7:0]      acc_wdata,
  // answer in
  input  wire logic [7:0] acc_rdata_ff,
  input  wire logic       acc_rvalid_ff,
  input  wire logic       ext_req_ff,
  input  wire logic       latch_read_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {acc_valid, acc_write, acc_ext, acc_adr, acc_wdata} = 19'h0;
  end
  // reserved addresses go out only when the bench asks, to see them ignored
  task automatic acc(input logic w, e, input logic [7:0] a, d, output logic [7:0] q, output logic [2:0] p);
    @(posedge core_clk);
    {acc_valid, acc_write, acc_ext, acc_adr, acc_wdata} <= {1'b1, w, e, a, d};
    @(posedge core_clk);
    acc_valid <= 1'b0;
    // released lines must not keep looking like the last access
    acc_adr   <= ~a;
    acc_wdata <= ~d;
    #1;
    q = acc_rdata_ff;
    p = {acc_rvalid_ff, ext_req_ff, latch_read_ff};
  endtask
endmodule // ulpirm_link_model

//--- test/ulpirm_bank_tb.sv
// self-checking bench for the ulpi register bank
// assumes the link model as the only source of accesses
module ulpirm_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] IDS = 32'h64636261; // arbitrary values
  logic       core_clk = 1'b0;
  logic       rstn     = 1'b0;
  logic [7:0] irq_state, irq_events, line_debug, q;
  logic [2:0] p;
  wire  [7:0] acc_adr, acc_wdata, acc_rdata_ff, func_ctrl, ifc_ctrl, dual_ctrl, irq_en_rise, irq_en_fall;
  wire  [7:0] scratch, pwr_ctrl;
  wire        acc_valid, acc_write, acc_ext, acc_rvalid_ff, ext_req_ff, latch_read_ff;
  int         bad_count = 0;
  int         samples_checked = 0;
  logic [7:0] base [7] = '{8'h04, 8'h07, 8'h0A, 8'h0D, 8'h10, 8'h16, 8'h3D};
  logic [7:0] ro [7]   = '{8'h13, 8'h14, 8'h15, 8'h19, 8'h2E, 8'h3C, 8'h44};
  always #5 core_clk = ~core_clk;
  ulpirm_bank #(.VEND_CODE_LO(IDS[7:0]), .VEND_CODE_HI(IDS[15:8]), .PART_CODE_LO(IDS[23:16]),
    .PART_CODE_HI(IDS[31:24])) u_ulpirm_bank (.core_clk, .rstn, .acc_valid, .acc_write, .acc_ext, .acc_adr,
    .acc_wdata, .acc_rdata_ff, .acc_rvalid_ff, .ext_req_ff, .irq_state, .irq_events, .line_debug, .func_ctrl,
    .ifc_ctrl, .dual_ctrl, .irq_en_rise, .irq_en_fall, .scratch, .pwr_ctrl, .latch_read_ff);
  ulpirm_link_model u_ulpirm_link_model (.core_clk, .acc_valid, .acc_write, .acc_ext, .acc_adr, .acc_wdata,
    .acc_rdata_ff, .acc_rvalid_ff, .ext_req_ff, .latch_read_ff);
  function automatic logic [7:0] reg_of(input logic [7:0] a);
    case (a)
      8'h04: reg_of = func_ctrl;
      8'h07: reg_of = ifc_ctrl;
      8'h0A: reg_of = dual_ctrl;
      8'h0D: reg_of = irq_en_rise;
      8'h10: reg_of = irq_en_fall;
      8'h16: reg_of = scratch;
      default: reg_of = pwr_ctrl;
    endcase
  endfunction
  task automatic chk(input string n, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results;
    $display("bad_count %0d samples_checked %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic e, input logic [7:0] a, d);
    u_ulpirm_link_model.acc(1'b1, e, a, d, q, p);
  endtask
  task automatic rd(input logic e, input logic [7:0] a);
    u_ulpirm_link_model.acc(1'b0, e, a, 8'h00, q, p);
  endtask
  // about 64 accesses of two cycles each, so this is ample
  initial begin
    #50us;
    bad_count++;
    results();
  end
  initial begin
    {irq_state, irq_events, line_debug} = 24'h96693C;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    for (int i = 0; i < 7; i++) begin
      chk("reset value", (i == 0) ? 8'h41 : 8'h00, reg_of(base[i]));
    end
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, 8'(i), 8'hFF);
      rd(1'b0, 8'(i));
      chk("id byte", IDS[i*8+:8], q);
    end
    for (int i = 0; i < 7; i++) begin
      wr(i == 6, base[i], 8'hA5);
      chk("write", 8'hA5, reg_of(base[i]));
      wr(1'b0, base[i] + 8'h01, 8'h0A);
      chk("set", 8'hAF, reg_of(base[i]));
      wr(1'b0, base[i] + 8'h02, 8'h21);
      chk("clear", 8'h8E, reg_of(base[i]));
      for (int k = 0; k < 3; k++) begin
        rd(k == 2, base[i] + 8'(k));
        chk("read", 8'h8E, q);
        chk("read pulses", 8'h04, {5'h00, p});
      end
    end
    for (int j = 0; j < 7; j++) begin
      wr(j == 6, ro[j], 8'h55);
      for (int i = 0; i < 7; i++) begin
        chk("no change", 8'h8E, reg_of(base[i]));
      end
    end
    rd(1'b0, 8'h13);
    chk("status", irq_state, q);
    rd(1'b0, 8'h14);
    chk("latch", irq_events, q);
    chk("latch pulses", 8'h05, {5'h00, p});
    rd(1'b0, 8'h15);
    chk("debug", line_debug, q);
    rd(1'b0, 8'h20);
    chk("reserved", 8'h00, q);
    wr(1'b0, 8'h2F, 8'h55);
    chk("ext pulses", 8'h02, {5'h00, p});
    wr(1'b1, 8'h2F, 8'h55);
    chk("ext alias pulses", 8'h00, {5'h00, p});
    for (int i = 0; i < 7; i++) begin
      chk("ext no store", 8'h8E, reg_of(base[i]));
    end
    // a second reset in mid-run must bring every register back
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    for (int i = 0; i < 7; i++) begin
      chk("reset again", (i == 0) ? 8'h41 : 8'h00, reg_of(base[i]));
    end
    rd(1'b0, 8'h04);
    chk("read after reset", 8'h41, q);
    results();
  end
endmodule // ulpirm_bank_tb
